/* design/dbm_cfg.svh */
/*
 * Constants of the debug break-condition matcher: register offsets, field
 * positions and reset values. Assumes it is included by bare name from the
 * package and the design file.
 */
// Functional notes
// [RULE1] break when bus address or program counter equals the set address
// [RULE2] break on data match at byte, word or longword size
// [RULE3] break when X or Y bus address or data equals the set value
// [RULE4] optional read/write level qualifier with programmed polarity
// [RULE5] optional bus-state qualifier on the current cycle's type
// [RULE6] cpu-all selection covers fetches and data, cache hits included
// [RULE7] cpu-data selection covers data accesses only, hits included
// [RULE8] internal-bus selection covers cache misses and dma data accesses
// [RULE9] break on any access to internal peripheral i/o space
// [RULE10] break when the tlb-entry load instruction executes
// [RULE11] count qualifier delays the break until n matches seen
// [RULE12] three channels with differing condition subsets
// [RULE13] debugger picks internal bus for on-chip ram via cached region
// [RULE14] debugger picks local bus for on-chip ram via uncached region
// [RULE15] debugger picks internal bus to catch cache line fills
// [RULE16] cache-miss performance counter readable by the debugger
// [RULE17] break only when all enabled conditions match in one cycle; channel three breaks on either enabled term instead
// [RULE18] all channel breaks ored into one halt request
`ifndef DBM_CFG_SVH
`define DBM_CFG_SVH
// ==========================================================================
// register offsets (byte addresses)
`define DBM_OFS_C1CTL   8'h00
`define DBM_OFS_C1ADR   8'h04
`define DBM_OFS_C1DAT   8'h08
`define DBM_OFS_C1CNT   8'h0c
`define DBM_OFS_C2CTL   8'h10
`define DBM_OFS_C2ADR   8'h14
`define DBM_OFS_C3CTL   8'h18
`define DBM_OFS_STAT    8'h1c
`define DBM_OFS_MASK    8'h20
`define DBM_OFS_PERF    8'h24
`define DBM_OFS_C1CUR   8'h28
// ==========================================================================
// control field positions
`define DBM_B_ADR_EN    0
`define DBM_B_PC_EN     1
`define DBM_B_DAT_EN    2
`define DBM_B_RW_EN     3
`define DBM_B_RW_POL    4
`define DBM_B_BS_EN     5
`define DBM_B_BS_LO     6
`define DBM_B_BS_HI     7
`define DBM_B_SZ_LO     8
`define DBM_B_SZ_HI     9
`define DBM_B_XY_EN     10
`define DBM_B_XY_SEL    11
`define DBM_B_CNT_EN    12
`define DBM_B_IO_EN     0
`define DBM_B_TLB_EN    1
// ==========================================================================
// reset values
`define DBM_RST_WORD    32'h0000_0000
`define DBM_RST_STAT    3'h0
`endif

/* design/dbm_pkg.sv */
/*
 * Types of the debug break-condition matcher.
 * Assumes dbm_cfg.svh is on the include path.
 */
`include "dbm_cfg.svh"
package dbm_pkg;
    // bus-state selection, code in control bits 7:6
    typedef enum logic [1:0] {
        DBM_BS_CPU_ALL  = 2'h0,
        DBM_BS_CPU_DATA = 2'h1,
        DBM_BS_IBUS     = 2'h2,
        DBM_BS_NONE     = 2'h3
    } dbm_bs_e;
    // compare size, code in control bits 9:8
    typedef enum logic [1:0] {
        DBM_SZ_BYTE = 2'h0,
        DBM_SZ_WORD = 2'h1,
        DBM_SZ_LONG = 2'h2,
        DBM_SZ_RSV  = 2'h3
    } dbm_sz_e;
endpackage : dbm_pkg

/* design/dbm_matcher.sv */
/*
 * Debug break-condition matcher: three condition channels watching the
 * processor buses, one halt request, a cache-miss counter and registers.
 * Assumes bus observation inputs come from logic on clk, one record per
 * cycle qualified by its valid bit; register port per plain strobe bus.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dbm_cfg.svh"
module dbm_matcher
    import dbm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        lb_valid,
    input  wire logic        lb_ifetch,
    input  wire logic        lb_cache_hit,
    input  wire logic        ib_valid,
    input  wire logic        ib_dma,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_data,
    input  wire logic [1:0]  bus_size,
    input  wire logic        read_write_direction,
    input  wire logic        pc_valid,
    input  wire logic [31:0] pc_value,
    input  wire logic        xy_valid,
    input  wire logic        xy_is_y,
    input  wire logic [31:0] xy_addr,
    input  wire logic [31:0] xy_data,
    input  wire logic        io_access,
    input  wire logic        tlb_entry_load_instruction,
    input  wire logic        cache_miss,
    output logic             halt_req,
    output logic             irq
);
    import dbm_pkg::*;

    // ======================================================================
    // configuration registers
    logic [31:0] c1ctl_ff;
    logic [31:0] c1adr_ff;
    logic [31:0] c1dat_ff;
    logic [31:0] c1cnt_ff;
    logic [31:0] c2ctl_ff;
    logic [31:0] c2adr_ff;
    logic [31:0] c3ctl_ff;
    logic [2:0]  mask_ff;
    logic [2:0]  stat_ff;
    logic [31:0] perf_ff;
    logic [31:0] c1cur_ff;

    // software writes; unmapped offsets are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c1ctl_ff <= `DBM_RST_WORD;
            c1adr_ff <= `DBM_RST_WORD;
            c1dat_ff <= `DBM_RST_WORD;
            c1cnt_ff <= `DBM_RST_WORD;
            c2ctl_ff <= `DBM_RST_WORD;
            c2adr_ff <= `DBM_RST_WORD;
            c3ctl_ff <= `DBM_RST_WORD;
            mask_ff  <= `DBM_RST_STAT;
        end else if (reg_wr) begin
            if (reg_addr == `DBM_OFS_C1CTL) begin
                c1ctl_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C1ADR) begin
                c1adr_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C1DAT) begin
                c1dat_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C1CNT) begin
                c1cnt_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C2CTL) begin
                c2ctl_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C2ADR) begin
                c2adr_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_C3CTL) begin
                c3ctl_ff <= reg_wdata;
            end else if (reg_addr == `DBM_OFS_MASK) begin
                mask_ff <= reg_wdata[2:0];
            end
        end
    end

    // ======================================================================
    // per-cycle condition terms
    // bus signals come in as arguments: a continuous assignment only wakes
    // on its own operands, so reading them from inside would go stale
    function automatic logic bs_ok(
        input logic [1:0] sel,
        input logic       lbv,
        input logic       fetch,
        input logic       chit,
        input logic       ibv,
        input logic       dma
    );
        case (dbm_bs_e'(sel))
            DBM_BS_CPU_ALL:  bs_ok = lbv;                   // see [RULE6]
            DBM_BS_CPU_DATA: bs_ok = lbv && !fetch;         // see [RULE7]
            DBM_BS_IBUS:     bs_ok = ibv && (dma || !chit); // see [RULE8]
            default:         bs_ok = 1'b0;
        endcase
    endfunction : bs_ok

    // data compare on the lanes the chosen size covers; bus values are
    // arguments for the same wake-up reason as above
    function automatic logic dat_ok(
        input logic [31:0] ref_v,
        input logic [1:0]  sz,
        input logic [1:0]  bsz,
        input logic [31:0] bdat
    );
        case (dbm_sz_e'(sz))
            DBM_SZ_BYTE: dat_ok = (bsz == sz) && bdat[7:0] == ref_v[7:0];
            DBM_SZ_WORD: dat_ok = (bsz == sz) && bdat[15:0] == ref_v[15:0];
            DBM_SZ_LONG: dat_ok = (bsz == sz) && bdat == ref_v;
            default:     dat_ok = 1'b0;
        endcase
    endfunction : dat_ok

    logic        bus_cyc;
    logic        c1_adr;
    logic        c1_dat;
    logic        c1_rw;
    logic        c1_bs;
    logic        c1_xy;
    logic        c1_hit;
    logic        c2_adr;
    logic        c2_rw;
    logic        c2_bs;
    logic        c2_hit;
    logic        c3_hit;
    logic        c1_any;
    logic        c2_any;
    logic [31:0] nxt_c1cur;
    logic        c1_fire;

    assign bus_cyc = lb_valid || ib_valid;
    // disabled terms count as true; all enabled terms judged together
    assign c1_adr = (!c1ctl_ff[`DBM_B_ADR_EN] || (bus_cyc && bus_addr == c1adr_ff))
                 && (!c1ctl_ff[`DBM_B_PC_EN] || (pc_valid && pc_value == c1adr_ff)); // see [RULE1]
    assign c1_dat = !c1ctl_ff[`DBM_B_DAT_EN]
                 || (bus_cyc && dat_ok(c1dat_ff, c1ctl_ff[`DBM_B_SZ_HI:`DBM_B_SZ_LO],
                                       bus_size, bus_data)); // see [RULE2]
    assign c1_xy  = !c1ctl_ff[`DBM_B_XY_EN] || (xy_valid
                 && xy_is_y == c1ctl_ff[`DBM_B_XY_SEL]
                 && (xy_addr == c1adr_ff || xy_data == c1dat_ff)); // see [RULE3]
    assign c1_rw  = !c1ctl_ff[`DBM_B_RW_EN]
                 || (bus_cyc && read_write_direction == c1ctl_ff[`DBM_B_RW_POL]); // see [RULE4]
    assign c1_bs  = !c1ctl_ff[`DBM_B_BS_EN]
                 || bs_ok(c1ctl_ff[`DBM_B_BS_HI:`DBM_B_BS_LO], lb_valid, lb_ifetch,
                          lb_cache_hit, ib_valid, ib_dma); // see [RULE5]
    // only enable bits arm the channel; polarity, selector and size do not
    assign c1_any = c1ctl_ff[`DBM_B_ADR_EN] || c1ctl_ff[`DBM_B_PC_EN]
                 || c1ctl_ff[`DBM_B_DAT_EN] || c1ctl_ff[`DBM_B_RW_EN]
                 || c1ctl_ff[`DBM_B_BS_EN] || c1ctl_ff[`DBM_B_XY_EN];
    assign c1_hit = c1_any && c1_adr && c1_dat && c1_xy && c1_rw && c1_bs; // see [RULE17]

    // channel two: address or pc, read/write and bus state only
    assign c2_adr = (!c2ctl_ff[`DBM_B_ADR_EN] || (bus_cyc && bus_addr == c2adr_ff))
                 && (!c2ctl_ff[`DBM_B_PC_EN] || (pc_valid && pc_value == c2adr_ff)); // see [RULE12]
    assign c2_rw  = !c2ctl_ff[`DBM_B_RW_EN]
                 || (bus_cyc && read_write_direction == c2ctl_ff[`DBM_B_RW_POL]);
    assign c2_bs  = !c2ctl_ff[`DBM_B_BS_EN]
                 || bs_ok(c2ctl_ff[`DBM_B_BS_HI:`DBM_B_BS_LO], lb_valid, lb_ifetch,
                          lb_cache_hit, ib_valid, ib_dma);
    assign c2_any = c2ctl_ff[`DBM_B_ADR_EN] || c2ctl_ff[`DBM_B_PC_EN]
                 || c2ctl_ff[`DBM_B_RW_EN] || c2ctl_ff[`DBM_B_BS_EN];
    assign c2_hit = c2_any && c2_adr && c2_rw && c2_bs; // see [RULE17]

    // channel three: internal i/o and tlb load only
    assign c3_hit = (c3ctl_ff[`DBM_B_IO_EN] && io_access)                     // see [RULE9]
                 || (c3ctl_ff[`DBM_B_TLB_EN] && tlb_entry_load_instruction); // see [RULE10]

    // ======================================================================
    // match counter: counts hits, fires on each hit once the tally reaches the programmed count
    always_comb begin
        nxt_c1cur = c1cur_ff;
        c1_fire   = c1_hit;
        if (c1ctl_ff[`DBM_B_CNT_EN]) begin
            c1_fire = 1'b0;
            if (c1_hit) begin
                nxt_c1cur = c1cur_ff + 32'h1;
                c1_fire   = (nxt_c1cur >= c1cnt_ff); // see [RULE11]
            end
        end
    end

    // writing the count target restarts the tally
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c1cur_ff <= `DBM_RST_WORD;
        end else if (reg_wr && reg_addr == `DBM_OFS_C1CNT) begin
            c1cur_ff <= `DBM_RST_WORD;
        end else begin
            c1cur_ff <= nxt_c1cur;
        end
    end

    // ======================================================================
    // sticky status, write one to clear; a new hit beats the clear
    logic [2:0] hits;
    logic [2:0] clr;
    assign hits = {c3_hit, c2_hit, c1_fire};
    assign clr  = (reg_wr && reg_addr == `DBM_OFS_STAT) ? reg_wdata[2:0] : 3'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_ff <= `DBM_RST_STAT;
        end else begin
            stat_ff <= (stat_ff & ~clr) | hits;
        end
    end

    // halt request is a registered or of the channel hits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halt_req <= 1'b0;
            irq      <= 1'b0;
        end else begin
            halt_req <= |hits; // see [RULE18]
            irq      <= |(((stat_ff & ~clr) | hits) & mask_ff);
        end
    end

    // cache-miss tally; writing the offset sets a new start value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            perf_ff <= `DBM_RST_WORD;
        end else if (reg_wr && reg_addr == `DBM_OFS_PERF) begin
            perf_ff <= reg_wdata;
        end else if (cache_miss) begin
            perf_ff <= perf_ff + 32'h1; // see [RULE16]
        end
    end

    // ======================================================================
    // read port, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= `DBM_RST_WORD;
        end else if (reg_rd) begin
            if (reg_addr == `DBM_OFS_C1CTL) begin
                reg_rdata <= c1ctl_ff;
            end else if (reg_addr == `DBM_OFS_C1ADR) begin
                reg_rdata <= c1adr_ff;
            end else if (reg_addr == `DBM_OFS_C1DAT) begin
                reg_rdata <= c1dat_ff;
            end else if (reg_addr == `DBM_OFS_C1CNT) begin
                reg_rdata <= c1cnt_ff;
            end else if (reg_addr == `DBM_OFS_C2CTL) begin
                reg_rdata <= c2ctl_ff;
            end else if (reg_addr == `DBM_OFS_C2ADR) begin
                reg_rdata <= c2adr_ff;
            end else if (reg_addr == `DBM_OFS_C3CTL) begin
                reg_rdata <= c3ctl_ff;
            end else if (reg_addr == `DBM_OFS_STAT) begin
                reg_rdata <= {29'h0, stat_ff};
            end else if (reg_addr == `DBM_OFS_MASK) begin
                reg_rdata <= {29'h0, mask_ff};
            end else if (reg_addr == `DBM_OFS_PERF) begin
                reg_rdata <= perf_ff;
            end else if (reg_addr == `DBM_OFS_C1CUR) begin
                reg_rdata <= c1cur_ff;
            end else begin
                reg_rdata <= 32'h0;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule : dbm_matcher
`default_nettype wire

/* dv/dbm_matcher_monitor.sv */
/* port checker of the break matcher.
   assumes bind to dbm_matcher, shadows the words it programs */
`timescale 1ns/10ps
`default_nettype none
`include "dbm_cfg.svh"
module dbm_mon (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        lb_valid,
    input wire logic        ib_valid,
    input wire logic [31:0] bus_addr,
    input wire logic        pc_valid,
    input wire logic [31:0] pc_value,
    input wire logic        xy_valid,
    input wire logic        io_access,
    input wire logic        tlb_entry_load_instruction,
    input wire logic        halt_req,
    input wire logic        irq
);
    logic [31:0] c1ctl_ff, c1adr_ff;
    logic [1:0]  c3ctl_ff;
    logic [2:0]  mask_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ======================================================
    // shadow words, taken on the same edge as the design
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c1ctl_ff <= '0;
            c1adr_ff <= '0;
            c3ctl_ff <= '0;
            mask_ff  <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `DBM_OFS_C1CTL) c1ctl_ff <= reg_wdata;
            if (reg_addr == `DBM_OFS_C1ADR) c1adr_ff <= reg_wdata;
            if (reg_addr == `DBM_OFS_C3CTL) c3ctl_ff <= reg_wdata[1:0];
            if (reg_addr == `DBM_OFS_MASK) mask_ff <= reg_wdata[2:0];
        end
    end
    sequence s_io; io_access && c3ctl_ff[`DBM_B_IO_EN]; endsequence
    sequence s_tlb; tlb_entry_load_instruction && c3ctl_ff[`DBM_B_TLB_EN]; endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_halt_cause: assert property (halt_req |-> $past(lb_valid || ib_valid
        || pc_valid || xy_valid || io_access || tlb_entry_load_instruction))
        else $error("halt without bus activity");
    a_addr_hit: assert property (c1ctl_ff == 32'h1 && lb_valid && bus_addr == c1adr_ff
        |=> halt_req) else $error("address hit missed");
    a_pc_hit: assert property (c1ctl_ff == 32'h2 && pc_valid && pc_value == c1adr_ff
        |=> halt_req) else $error("pc hit missed");
    a_io_hit: assert property (s_io |=> halt_req)
        else $error("io hit missed");
    a_tlb_hit: assert property (s_tlb |=> halt_req)
        else $error("tlb hit missed");
    // a mask write reaches irq two edges later: mask register, then irq flop
    a_irq_rise: assert property ($rose(irq) |-> halt_req || $past(reg_wr, 2))
        else $error("irq rose without cause");
    a_mask_off: assert property (mask_ff == 3'h0 && $past(mask_ff) == 3'h0 |-> !irq)
        else $error("irq while fully masked");
endmodule : dbm_mon
bind dbm_matcher dbm_mon u_mon (.*);
`default_nettype wire

/* dv/dbm_dbg_model.sv */
/* debugger model: masters the register port.
   assumes the plain strobe bus, one access then a one-cycle gap */
`timescale 1ns/10ps
`default_nettype none
module dbm_dbg
    import dbm_pkg::*;
(
    input  wire logic  clk,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
    end
    // ======================================================
    // one access; released lines show the inverse, not stale data
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : acc
    // fills and cached-region ram only show on the internal bus
    function automatic dbm_bs_e bs_pick(input logic cached, input logic fill);
        return (cached || fill) ? DBM_BS_IBUS : DBM_BS_CPU_ALL;
    endfunction : bs_pick
endmodule : dbm_dbg
`default_nettype wire

/* dv/test_dbm_matcher.sv */
/* self-checking bench of the break matcher.
   assumes dbm_dbg model and the bound checker */
`timescale 1ns/10ps
`default_nettype none
`include "dbm_cfg.svh"
module test_dbm_matcher;
    import dbm_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, halt_req, irq, tag_ff, tagd_ff, rdd_ff;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ad, dt, seed, a;
    logic [11:0] fl;
    logic [1:0]  sz;
    logic        exp_q[$];
    logic [31:0] rq[$];
    logic [11:0] kind[4] = '{12'h007, 12'h005, 12'h008, 12'h018};
    logic [15:0] bst = 16'h0c23;
    int          errors, checks, cyc, i;
    dbm_dbg u_dbg (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    dbm_matcher dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lb_valid(fl[0]),
        .lb_ifetch(fl[1]), .lb_cache_hit(fl[2]), .ib_valid(fl[3]), .ib_dma(fl[4]),
        .bus_addr(ad), .bus_data(dt), .bus_size(sz), .read_write_direction(fl[10]),
        .pc_valid(fl[5]), .pc_value(ad), .xy_valid(fl[6]), .xy_is_y(fl[7]), .xy_addr(ad),
        .xy_data(dt), .io_access(fl[8]), .tlb_entry_load_instruction(fl[9]),
        .cache_miss(fl[11]), .halt_req(halt_req), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] ra, input logic [31:0] d);
        u_dbg.acc(1'b1, ra, d);
    endtask : wr
    task automatic rd(input logic [7:0] ra, input logic [31:0] e);
        rq.push_back(e);
        u_dbg.acc(1'b0, ra, xs());
    endtask : rd
    // one observed bus cycle, halt expectation noted for the watcher
    task automatic ob(input logic [11:0] f, input logic e);
        @(posedge clk);
        fl <= f;
        tag_ff <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        fl <= '0;
        tag_ff <= 1'b0;
    endtask : ob
    // ======================================================
    // watcher: halt and read data land one edge after the request and are checked on the edge after that
    always @(posedge clk) begin
        tagd_ff <= tag_ff;
        rdd_ff <= reg_rd;
        cyc++;
        if (tagd_ff) chk(32'(halt_req), 32'(exp_q.pop_front()));
        if (rdd_ff) chk(reg_rdata, rq.pop_front());
        if (cyc > 6000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        {fl, ad, dt, sz, tag_ff, tagd_ff, rdd_ff, errors, checks, cyc} = '0;
        rst_n = 1'b0;
        seed = 32'd53;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i <= 12; i++) rd(8'(i * 4), 32'h0); // reset values, holes read 0
        a = xs();
        wr(`DBM_OFS_C1ADR, a);
        rd(`DBM_OFS_C1ADR, a);
        wr(`DBM_OFS_C1CTL, 32'h1);
        ad <= a;
        ob(12'h001, 1'b1);
        ad <= ~a;
        ob(12'h001, 1'b0);
        wr(`DBM_OFS_C1CTL, 32'h2);
        ad <= a;
        ob(12'h020, 1'b1);
        ob(12'h001, 1'b0);
        dt <= xs();
        @(posedge clk); // new data word must land before it is programmed
        for (i = 0; i < 3; i++) begin
            wr(`DBM_OFS_C1DAT, dt);
            wr(`DBM_OFS_C1CTL, 32'h4 | 32'(i) << 8);
            sz <= 2'(i);
            ob(12'h001, 1'b1);
            sz <= 2'(i + 1);
            ob(12'h001, 1'b0);
        end
        for (i = 0; i < 2; i++) begin
            wr(`DBM_OFS_C1CTL, 32'h400 | 32'(i) << 11);
            ob(12'h040 | 12'(i) << 7, 1'b1);
            ob(12'h040 | 12'(1 - i) << 7, 1'b0);
            wr(`DBM_OFS_C1CTL, 32'h9 | 32'(i) << 4);
            ob(12'h001 | 12'(i) << 10, 1'b1);
            ob(12'h001 | 12'(1 - i) << 10, 1'b0);
        end
        // qualifier fields alone, no enable bit: the channel stays quiet
        wr(`DBM_OFS_C1CTL, 32'h3d0);
        ob(12'h401, 1'b0);
        for (i = 0; i < 16; i++) begin
            wr(`DBM_OFS_C1CTL, 32'h21 | 32'(i / 4) << 6);
            ob(kind[i % 4], bst[i]);
        end
        wr(`DBM_OFS_C1CTL, 32'h21 | 32'(u_dbg.bs_pick(1'b1, 1'b0)) << 6);
        ob(12'h008, 1'b1);
        wr(`DBM_OFS_C1CTL, 32'h21 | 32'(u_dbg.bs_pick(1'b0, 1'b0)) << 6);
        ob(12'h001, 1'b1);
        wr(`DBM_OFS_C1CTL, 32'h21 | 32'(u_dbg.bs_pick(1'b0, 1'b1)) << 6);
        ob(12'h008, 1'b1);
        wr(`DBM_OFS_C1CNT, 32'h3);
        wr(`DBM_OFS_C1CTL, 32'h1001);
        for (i = 0; i < 4; i++) ob(12'h001, i >= 2);
        rd(`DBM_OFS_C1CUR, 32'h4);
        wr(`DBM_OFS_C1CTL, 32'h0);
        wr(`DBM_OFS_STAT, 32'h7);
        wr(`DBM_OFS_MASK, 32'h4);
        wr(`DBM_OFS_C3CTL, 32'h3);
        ob(12'h100, 1'b1);
        ob(12'h200, 1'b1);
        chk(32'(irq), 32'h1);
        rd(`DBM_OFS_STAT, 32'h4);
        wr(`DBM_OFS_STAT, 32'h4);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        ob(12'h100, 1'b1);
        wr(`DBM_OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        rd(`DBM_OFS_STAT, 32'h4);
        wr(`DBM_OFS_C3CTL, 32'h0);
        wr(`DBM_OFS_C2ADR, a);
        wr(`DBM_OFS_C2CTL, 32'h4);
        ob(12'h001, 1'b0);
        wr(`DBM_OFS_C2CTL, 32'h1);
        ob(12'h001, 1'b1);
        rd(`DBM_OFS_STAT, 32'h6);
        wr(`DBM_OFS_PERF, 32'h0);
        for (i = 0; i < 5; i++) ob(12'h800, 1'b0);
        rd(`DBM_OFS_PERF, 32'h5);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule : test_dbm_matcher
`default_nettype wire
